// *** rtl/imr_defs.svh ***
// offsets, field positions, reset values and counts for the integrity monitor registers
`ifndef IMR_DEFS_SVH
`define IMR_DEFS_SVH

// ***************************************
// register byte offsets
// ***************************************
`define IMR_OFF_CFG     8'h00
`define IMR_OFF_CMD     8'h04
`define IMR_OFF_STATUS  8'h08
`define IMR_OFF_IER     8'h10
`define IMR_OFF_IDR     8'h14
`define IMR_OFF_IMR     8'h18
`define IMR_OFF_ISR     8'h1c
`define IMR_OFF_TRACE   8'h20
`define IMR_OFF_DSCR    8'h30
`define IMR_OFF_HASH    8'h34
`define IMR_OFF_IHV0    8'h38
`define IMR_OFF_IHV7    8'h54

// ***************************************
// configuration word fields
// ***************************************
`define IMR_CFG_WB_BLOCK    0
`define IMR_CFG_END_BLOCK   1
`define IMR_CFG_BR_BLOCK    2
`define IMR_CFG_BURDEN_LSB  4
`define IMR_CFG_AUTO        8
`define IMR_CFG_TWIN        9
`define IMR_CFG_CUSTOM_IV   12
`define IMR_CFG_CUSTOM_KIND_LSB 13
`define IMR_CFG_MASK        32'h0000f3f7
`define IMR_CFG_RESET       32'h00000000

// ***************************************
// command word fields
// ***************************************
`define IMR_CMD_ENABLE      0
`define IMR_CMD_DISABLE     1
`define IMR_CMD_SOFT_RESET  2
`define IMR_CMD_RECOMPUTE_DIGEST_LSB  4
`define IMR_CMD_OFF_LSB     8
`define IMR_CMD_ON_LSB      12

// ***************************************
// interrupt word fields, trace codes, descriptor mask and counts
// ***************************************
`define IMR_IRQ_DONE_LSB    0
`define IMR_IRQ_MISM_LSB    4
`define IMR_IRQ_BERR_LSB    8
`define IMR_IRQ_WRAP_LSB    12
`define IMR_IRQ_END_LSB     16
`define IMR_IRQ_UPD_LSB     20
`define IMR_IRQ_BAD         24
`define IMR_IRQ_WIDTH       25
`define IMR_TRACE_MEMBER    3'h0
`define IMR_TRACE_CFG       3'h1
`define IMR_TRACE_DSCR      3'h2
`define IMR_TRACE_HASH      3'h3
`define IMR_TRACE_READ      3'h4
`define IMR_DSCR_MASK       32'hffffffc0
`define IMR_REGIONS         4
`define IMR_IHV_WORDS       8

`endif

// *** rtl/imr_pkg.sv ***
// types shared by the integrity monitor register bank
`include "imr_defs.svh"
package imr_pkg;

   typedef enum logic [1:0] {
      IMR_SHA1   = 2'b00,
      IMR_SHA256 = 2'b01,
      IMR_SHA224 = 2'b10
   } imr_hash_kind_t;

   // events reported by the list walker and hash engine, one-cycle pulses
   typedef struct packed {
      logic [3:0] region_done_flag;
      logic [3:0] digest_mismatch_flag;
      logic [3:0] region_bus_fault;
      logic [3:0] wrap_seen_flag;
      logic [3:0] end_seen_flag;
      logic [3:0] region_update_flag;
      logic bad_member;
   } imr_event_t;

   // effective controls handed to the walker and hash engine
   typedef struct packed {
      logic monitor_on;
      logic disable_pulse;
      logic soft_reset_pulse;
      logic [3:0] region_watch;
      logic [3:0] recompute_digest_pulse;
      logic force_no_writeback;
      logic ignore_desc_writeback;
      logic ignore_desc_eom;
      logic branch_block;
      logic [15:0] idle_cycles;
      logic auto_compare;
      logic twin_input_buffer;
      logic custom_initial_digest;
      imr_hash_kind_t hash_kind;
      logic [31:0] descriptor_base;
      logic [31:0] digest_base;
      logic [7:0][31:0] init_hash;
   } imr_ctrl_t;

   // whole register state
   typedef struct packed {
      logic [31:0] cfg;
      logic enabled;
      logic disable_p;
      logic soft_rst_p;
      logic [3:0] recompute_digest_p;
      logic [3:0] watch_off;
      logic [24:0] mask;
      logic [24:0] flags;
      logic [2:0] trace;
      logic [31:0] dscr;
      logic [31:0] hash;
      logic [7:0][31:0] ihv;
      logic [31:0] rdata;
   } imr_state_t;

endpackage

// *** rtl/imr_regs.sv ***
// register bank of the integrity monitor: apb slave, config, command, status, irq, trace
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "imr_defs.svh"

module imr_regs
   import imr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire imr_event_t events,
   input wire logic [3:0] region_digest_ready,
   input wire logic monitoring_active,
   output imr_ctrl_t ctrl,
   output logic irq
);

   // ***************************************
   // helpers
   // ***************************************

   // custom algorithm decode; unlisted codes fall back to sha1
   function automatic imr_hash_kind_t decode_hash_kind(input logic [2:0] code);
      imr_hash_kind_t a;
      a = IMR_SHA1;
      if (code == 3'h1) begin
         a = IMR_SHA256;
      end else if (code == 3'h4) begin
         a = IMR_SHA224;
      end
      return a;
   endfunction

   // true for offsets that software may only write
   function automatic logic is_write_only(input logic [7:0] a);
      return (a == `IMR_OFF_CMD) || (a == `IMR_OFF_IER) || (a == `IMR_OFF_IDR) ||
             ((a >= `IMR_OFF_IHV0) && (a <= `IMR_OFF_IHV7) && (a[1:0] == 2'b00));
   endfunction

   // ***************************************
   // state
   // ***************************************
   imr_state_t s_q;
   imr_state_t s_d;
   logic setup;
   logic wr_acc;
   logic rd_acc;
   logic [31:0] rd_val;
   logic [24:0] ev_bits;
   logic [2:0] bad_code;
   logic bad_hit;
   logic [2:0] ihv_idx;

   // zero wait states: read data is latched during setup, access completes at once
   assign pready = psel & penable;
   assign pslverr = 1'b0;
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign prdata = s_q.rdata;
   assign ihv_idx = 3'((paddr - `IMR_OFF_IHV0) >> 2);

   // events packed into the flag layout
   assign ev_bits = {events.bad_member, events.region_update_flag, events.end_seen_flag,
                     events.wrap_seen_flag, events.region_bus_fault,
                     events.digest_mismatch_flag, events.region_done_flag};

   // ***************************************
   // read multiplexer
   // ***************************************
   always_comb begin
      rd_val = 32'h0;
      unique case (paddr)
         `IMR_OFF_CFG: rd_val = s_q.cfg;
         `IMR_OFF_STATUS: begin
            rd_val[0] = s_q.enabled;
            rd_val[11:8] = s_q.watch_off;
            rd_val[15:12] = s_q.watch_off | ~region_digest_ready;
         end
         `IMR_OFF_IMR: rd_val[24:0] = s_q.mask;
         `IMR_OFF_ISR: rd_val[24:0] = s_q.flags;
         `IMR_OFF_TRACE: rd_val[2:0] = s_q.trace;
         `IMR_OFF_DSCR: rd_val = s_q.dscr;
         `IMR_OFF_HASH: rd_val = s_q.hash;
         default: rd_val = 32'h0;
      endcase
   end

   // ***************************************
   // undefined access detection
   // ***************************************

   // lowest code wins when several happen in one cycle; only the first is kept anyway
   always_comb begin
      bad_hit = 1'b1;
      bad_code = `IMR_TRACE_MEMBER;
      if (events.bad_member) begin
         bad_code = `IMR_TRACE_MEMBER;
      end else if (wr_acc && monitoring_active && paddr == `IMR_OFF_CFG) begin
         bad_code = `IMR_TRACE_CFG;
      end else if (wr_acc && monitoring_active && paddr == `IMR_OFF_DSCR) begin
         bad_code = `IMR_TRACE_DSCR;
      end else if (wr_acc && monitoring_active && paddr == `IMR_OFF_HASH) begin
         bad_code = `IMR_TRACE_HASH;
      end else if (rd_acc && is_write_only(paddr)) begin
         bad_code = `IMR_TRACE_READ;
      end else begin
         bad_hit = 1'b0;
      end
   end

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      s_d = s_q;
      s_d.disable_p = 1'b0;
      s_d.soft_rst_p = 1'b0;
      s_d.recompute_digest_p = 4'h0;
      if (setup) begin
         s_d.rdata = rd_val;
      end
      // flags: a read clears only the bits it handed out, so an event landing at
      // the setup edge is not lost; a same-cycle event still sets
      if (rd_acc && paddr == `IMR_OFF_ISR) begin
         s_d.flags[23:0] = s_q.flags[23:0] & ~s_q.rdata[23:0];
      end
      s_d.flags[23:0] = s_d.flags[23:0] | ev_bits[23:0];
      // first undefined access only; flag and trace survive everything but soft reset and presetn
      if (bad_hit && !s_q.flags[`IMR_IRQ_BAD]) begin
         s_d.flags[`IMR_IRQ_BAD] = 1'b1;
         s_d.trace = bad_code;
      end
      if (wr_acc) begin
         unique case (paddr)
            `IMR_OFF_CFG: s_d.cfg = pwdata & `IMR_CFG_MASK;
            `IMR_OFF_CMD: begin
               if (pwdata[`IMR_CMD_ENABLE]) begin
                  s_d.enabled = 1'b1;
               end
               if (pwdata[`IMR_CMD_DISABLE]) begin
                  s_d.enabled = 1'b0;
                  s_d.disable_p = 1'b1;
               end
               // only regions whose monitoring is already off may recompute_digest
               s_d.recompute_digest_p = pwdata[`IMR_CMD_RECOMPUTE_DIGEST_LSB +: 4] & s_q.watch_off;
               s_d.watch_off = (s_q.watch_off | pwdata[`IMR_CMD_OFF_LSB +: 4])
                               & ~pwdata[`IMR_CMD_ON_LSB +: 4];
            end
            `IMR_OFF_IER: s_d.mask = s_q.mask | pwdata[24:0];
            `IMR_OFF_IDR: s_d.mask = s_q.mask & ~pwdata[24:0];
            `IMR_OFF_DSCR: s_d.dscr = pwdata & `IMR_DSCR_MASK;
            `IMR_OFF_HASH: s_d.hash = pwdata;
            default: begin
               if (is_write_only(paddr) && paddr >= `IMR_OFF_IHV0) begin
                  s_d.ihv[ihv_idx] = pwdata;
               end
            end
         endcase
      end
      // soft reset restores every register but the read data latch, including the sticky trace
      if (wr_acc && paddr == `IMR_OFF_CMD && pwdata[`IMR_CMD_SOFT_RESET]) begin
         s_d = '0;
         s_d.cfg = `IMR_CFG_RESET;
         s_d.soft_rst_p = 1'b1;
         s_d.rdata = s_q.rdata;
      end
   end

   // ***************************************
   // state register
   // ***************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************
   // effective controls for walker and engine
   // ***************************************
   always_comb begin
      ctrl = '0;
      ctrl.monitor_on = s_q.enabled;
      ctrl.disable_pulse = s_q.disable_p;
      ctrl.soft_reset_pulse = s_q.soft_rst_p;
      ctrl.region_watch = ~s_q.watch_off;
      ctrl.recompute_digest_pulse = s_q.recompute_digest_p;
      ctrl.auto_compare = s_q.cfg[`IMR_CFG_AUTO];
      // auto compare owns the no-writeback bit, so the block bit is ignored there
      ctrl.force_no_writeback = s_q.cfg[`IMR_CFG_WB_BLOCK] & ~s_q.cfg[`IMR_CFG_AUTO];
      ctrl.ignore_desc_writeback = s_q.cfg[`IMR_CFG_WB_BLOCK] | s_q.cfg[`IMR_CFG_AUTO];
      ctrl.ignore_desc_eom = s_q.cfg[`IMR_CFG_END_BLOCK];
      ctrl.branch_block = s_q.cfg[`IMR_CFG_BR_BLOCK];
      ctrl.idle_cycles = 16'h1 << s_q.cfg[`IMR_CFG_BURDEN_LSB +: 4];
      ctrl.twin_input_buffer = s_q.cfg[`IMR_CFG_TWIN];
      ctrl.custom_initial_digest = s_q.cfg[`IMR_CFG_CUSTOM_IV];
      ctrl.hash_kind = decode_hash_kind(s_q.cfg[`IMR_CFG_CUSTOM_KIND_LSB +: 3]);
      ctrl.descriptor_base = s_q.dscr;
      ctrl.digest_base = s_q.hash;
      ctrl.init_hash = s_q.ihv;
   end

   // single interrupt line from flagged and unmasked events
   assign irq = |(s_q.flags & s_q.mask);

endmodule

// *** tb/imr_engine_model.sv ***
// stand-in for the list walker and hash engine
`timescale 1ns/1ps
module imr_engine_model
   import imr_pkg::*;
#(parameter int DLY = 6)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire imr_ctrl_t ctrl,
   input wire logic kick,
   output imr_event_t events,
   output logic [3:0] region_digest_ready,
   output logic monitoring_active
);
   int cnt;
   // digests land DLY cycles after start; a larger DLY mimics a slow engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         events <= '0;
      end else begin
         cnt <= ctrl.monitor_on ? (cnt < DLY ? cnt + 1 : cnt) : 0;
         events <= '0;
         events.region_done_flag[0] <= kick;
         // in auto compare the last descriptor carries the end flag, pulsed for region 0 with each kick; nothing stops on it
         events.end_seen_flag[0] <= kick & ctrl.auto_compare;
      end
   end
   assign region_digest_ready = ctrl.region_watch & {4{cnt == DLY}};
   assign monitoring_active = ctrl.monitor_on;
endmodule

// *** tb/imr_props.sv ***
// assertion checker for the integrity monitor register bank
`timescale 1ns/1ps
`include "imr_defs.svh"
module imr_props
   import imr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire imr_event_t events,
   input wire logic [3:0] region_digest_ready,
   input wire logic monitoring_active,
   input wire imr_ctrl_t ctrl,
   input wire logic irq
);
   // ************
   // write decode
   // ************
   logic cfg_w;
   logic cmd_w;
   assign cfg_w = psel && penable && pwrite && paddr == `IMR_OFF_CFG;
   // soft reset writes excluded, they clear everything but the read data latch
   assign cmd_w = psel && penable && pwrite && paddr == `IMR_OFF_CMD && !pwdata[2];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_WB: assert property (cfg_w |=> ctrl.force_no_writeback ==
      ($past(pwdata[0]) && !$past(pwdata[8]))) else $error("writeback block wrong");
   AST_IDLE: assert property (cfg_w |=> ctrl.idle_cycles ==
      (16'h1 << $past(pwdata[7:4]))) else $error("idle count wrong");
   AST_TWIN: assert property (cfg_w |=>
      ctrl.twin_input_buffer == $past(pwdata[9])) else $error("twin buffer wrong");
   AST_HASH_KIND: assert property (cfg_w |=> ctrl.hash_kind ==
      ($past(pwdata[15:13]) == 3'h1 ? IMR_SHA256 : $past(pwdata[15:13]) == 3'h4 ?
      IMR_SHA224 : IMR_SHA1)) else $error("algorithm decode wrong");
   AST_EN: assert property (cmd_w && pwdata[1:0] == 2'h1 |=>
      ctrl.monitor_on [*2]) else $error("enable lost");
   AST_DIS: assert property (cmd_w && pwdata[1] |=>
      ctrl.disable_pulse && !ctrl.monitor_on ##1 !ctrl.disable_pulse) else $error("disable");
   AST_SOFT_RESET_CMD: assert property (psel && penable && pwrite && paddr == `IMR_OFF_CMD &&
      pwdata[2] |=> ctrl.soft_reset_pulse && ctrl.descriptor_base == 32'h0 &&
      ctrl.region_watch == 4'hf) else $error("soft reset incomplete");
   AST_RECOMPUTE_DIGEST: assert property (cmd_w && pwdata[15:8] == 8'h0 |=>
      ctrl.recompute_digest_pulse == ($past(pwdata[7:4]) & ~$past(ctrl.region_watch)))
      else $error("recompute_digest wrong");
   AST_OFF: assert property (cmd_w |=> (ctrl.region_watch &
      $past(pwdata[11:8]) & ~$past(pwdata[15:12])) == 4'h0) else $error("region stays on");
   AST_ON: assert property (cmd_w |=> (ctrl.region_watch & $past(pwdata[15:12])) ==
      $past(pwdata[15:12])) else $error("region stays off");
   AST_DSCR: assert property (psel && penable && pwrite && paddr == `IMR_OFF_DSCR |=>
      ctrl.descriptor_base == ($past(pwdata) & `IMR_DSCR_MASK)) else $error("base wrong");
   AST_MODES: assert property (cfg_w |=>
      ctrl.ignore_desc_eom == $past(pwdata[1]) && ctrl.branch_block == $past(pwdata[2]) &&
      ctrl.auto_compare == $past(pwdata[8]) &&
      ctrl.ignore_desc_writeback == ($past(pwdata[0]) || $past(pwdata[8])) &&
      ctrl.custom_initial_digest == $past(pwdata[12])) else $error("mode bits wrong");
   AST_IHV: assert property (psel && penable && pwrite && paddr == `IMR_OFF_IHV7 |=>
      ctrl.init_hash[7] == $past(pwdata)) else $error("initial hash word wrong");
endmodule
bind imr_regs imr_props u_imr_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .events(events), .ctrl(ctrl), .irq(irq),
   .region_digest_ready(region_digest_ready), .monitoring_active(monitoring_active));

// *** tb/imr_regs_test.sv ***
// self-checking bench for the integrity monitor register bank
`timescale 1ns/1ps
`include "imr_defs.svh"
module imr_regs_test
   import imr_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, kick, pready, pslverr, irq, mon;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [3:0] dig;
   imr_event_t ev;
   imr_ctrl_t ctrl;
   logic [31:0] expq[$];
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;
   imr_regs u_imr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .events(ev), .region_digest_ready(dig), .monitoring_active(mon),
      .ctrl(ctrl), .irq(irq));
   imr_engine_model u_imr_engine_model (.pclk(pclk), .presetn(presetn), .ctrl(ctrl),
      .kick(kick), .events(ev), .region_digest_ready(dig), .monitoring_active(mon));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input string n, input logic [31:0] x, input logic [31:0] y);
      tests_run++;
      if (x !== y) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, x, y);
      end
   endtask
   task automatic check_bit(input string n, input logic x, input logic y);
      tests_run++;
      if (x !== y) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", n, x, y);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // read data is judged at the access edge, oldest note first
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         check_bit("pslverr", 1'b0, pslverr);
      end
      if (psel && penable && !pwrite && pready === 1'b1) begin
         check("prdata", expq.pop_front(), prdata);
      end
   end
   // hang guard: the whole sequence needs well under this
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 3000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      {psel, penable, pwrite, kick} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rnd = 32'h9f00cf0c;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`IMR_OFF_CFG, 32'h0);
      rd(`IMR_OFF_STATUS, 32'h0000f000);
      rd(`IMR_OFF_IMR, 32'h0);
      for (int a = 8'h38; a <= 8'h54; a += 4) rd(a[7:0], 32'h0);
      rd(8'h0c, 32'h0);
      rd(`IMR_OFF_CMD, 32'h0);
      rd(`IMR_OFF_TRACE, {29'h0, `IMR_TRACE_READ});
      rd(`IMR_OFF_ISR, 32'h01000000);
      // each initial hash word lands where the engine sees it, one edge later
      for (int a = 8'h38; a <= 8'h54; a += 4) begin
         rnd = lfsr(rnd);
         wr(a[7:0], rnd);
         @(posedge pclk);
         check("init_hash", rnd, ctrl.init_hash[(a - 8'h38) >> 2]);
      end
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         wr(`IMR_OFF_CFG, rnd);
         rd(`IMR_OFF_CFG, rnd & `IMR_CFG_MASK);
      end
      for (int k = 0; k < 3; k++) wr(`IMR_OFF_CFG, {16'h0, 3'(k == 2 ? 4 : k), 13'h1000});
      wr(`IMR_OFF_CFG, 32'h0);
      rnd = lfsr(rnd);
      wr(`IMR_OFF_DSCR, rnd);
      rd(`IMR_OFF_DSCR, rnd & `IMR_DSCR_MASK);
      wr(`IMR_OFF_HASH, ~rnd);
      rd(`IMR_OFF_HASH, ~rnd);
      wr(`IMR_OFF_CMD, 32'h1);
      repeat (8) @(posedge pclk);
      rd(`IMR_OFF_STATUS, 32'h1);
      wr(`IMR_OFF_CMD, 32'h100);
      rd(`IMR_OFF_STATUS, 32'h1101);
      wr(`IMR_OFF_CMD, 32'h10);
      wr(`IMR_OFF_CMD, 32'h1000);
      rd(`IMR_OFF_STATUS, 32'h1);
      wr(`IMR_OFF_IER, 32'h01000001);
      wr(`IMR_OFF_IDR, 32'h01000000);
      rd(`IMR_OFF_IMR, 32'h1);
      @(posedge pclk) kick <= 1'b1;
      @(posedge pclk) kick <= 1'b0;
      repeat (2) @(posedge pclk);
      check_bit("irq", 1'b1, irq);
      rd(`IMR_OFF_ISR, 32'h01000001);
      rd(`IMR_OFF_ISR, 32'h01000000);
      check_bit("irq", 1'b0, irq);
      wr(`IMR_OFF_CMD, 32'h2);
      rd(`IMR_OFF_STATUS, 32'h0000f000);
      wr(`IMR_OFF_CMD, 32'h4);
      rd(`IMR_OFF_TRACE, 32'h0);
      rd(`IMR_OFF_ISR, 32'h0);
      rd(`IMR_OFF_DSCR, 32'h0);
      // base and config changed while monitoring: first kind kept, writes still land
      wr(`IMR_OFF_CMD, 32'h1);
      wr(`IMR_OFF_DSCR, 32'h40);
      wr(`IMR_OFF_CFG, 32'h0);
      rd(`IMR_OFF_TRACE, {29'h0, `IMR_TRACE_DSCR});
      rd(`IMR_OFF_ISR, 32'h01000000);
      rd(`IMR_OFF_DSCR, 32'h40);
      complete_run();
   end
endmodule
